// *** hdl/map_decoder_defines.vh ***
// Constants for the memory map select decoder
`ifndef MAP_DECODER_DEFINES_VH
`define MAP_DECODER_DEFINES_VH
// Register byte addresses on the bus (index times four)
`define IDX_RAM_POSITION        8'h10
`define IDX_REG_POSITION        8'h11
`define IDX_EEPROM_POSITION     8'h12
`define IDX_MISC_CONTROL        8'h13
`define IDX_RESERVED_SLOT       8'h14
`define IDX_MODE_STATUS         8'h15
`define IDX_SELECT_STATUS       8'h16
`define ADDR_RAM_POSITION       8'h40
`define ADDR_REG_POSITION       8'h44
`define ADDR_EEPROM_POSITION    8'h48
`define ADDR_MISC_CONTROL       8'h4C
`define ADDR_RESERVED_SLOT      8'h50
`define ADDR_MODE_STATUS        8'h54
`define ADDR_SELECT_STATUS      8'h58
// Reset values of mapping registers
`define RST_RAM_POSITION        8'h09
`define RST_REG_POSITION        8'h00
`define RST_EEPROM_POSITION     8'h01
`define RST_MISC_CONTROL        8'h0D
// Misc control field positions
`define MISC_ONCHIP_ROM_ENABLE  0
`define MISC_PORT_E_EMUL        2
`define MISC_PORT_K_EMUL        3
// Region sizes, as upper-address masks
`define REG_SPACE_MASK          16'hFC00
`define RAM_SPACE_MASK          16'hF000
`define EEPROM_SPACE_MASK       16'hF000
`define FLASH_BASE              16'h4000
// Debug firmware window
`define DEBUG_BASE              16'hFF00
// Register offsets that move off-chip by mode
`define PORT_AB_LIMIT           10'h004
`define PORT_E_DATA             10'h008
`define PORT_E_DIR              10'h009
`define EXPANSION_LIMIT         10'h010
`define PORT_K_DATA             10'h032
`define PORT_K_DIR              10'h033
// One-hot select encoding
`define SEL_NONE                7'h00
`define SEL_DEBUG               7'h01
`define SEL_REGS                7'h02
`define SEL_RAM                 7'h04
`define SEL_EEPROM              7'h08
`define SEL_FLASH               7'h10
`define SEL_EXTERNAL            7'h20
`define SEL_UNMAPPED            7'h40
`endif

// *** hdl/mode_latch.v ***
// Operating mode capture at reset release; security re-read every clock
`timescale 1ns/100ps
`default_nettype none
`include "map_decoder_defines.vh"
module mode_latch
(
    input  wire       clk,
    input  wire       reset,
    input  wire       mode_pin_c,
    input  wire       mode_pin_b,
    input  wire       mode_pin_a,
    input  wire       security_bits_set,
    output reg  [2:0] mode,
    output reg        secured,
    output reg        captured
);
    // Strap capture on the first clock after release; flash bits are re-read
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mode     <= 3'h0;
            secured  <= 1'b1;
            captured <= 1'b0;
        end
        else
        begin
            // Security follows nonvolatile bits every cycle
            secured <= security_bits_set;
            if (!captured)
            begin
                mode     <= {mode_pin_c, mode_pin_b, mode_pin_a};
                captured <= 1'b1;
            end
        end
    end
endmodule // mode_latch
`default_nettype wire

// *** hdl/region_match.v ***
// Compare one address against a relocatable region base
`timescale 1ns/100ps
`default_nettype none
module region_match
(
    input  wire [15:0] address,
    input  wire [15:0] base,
    input  wire [15:0] mask,
    input  wire        enable,
    output wire        hit
);
    // Masked compare of upper address bits
    assign hit = enable && ((address & mask) == (base & mask));
endmodule // region_match
`default_nettype wire

// *** hdl/memory_map_select_decoder.v ***
// Address decode, select priority and mapping registers of the core
// Overview of operation
// - At most one block select at once
// - Overlap goes to highest priority block only
// - Debug, registers, RAM, EEPROM, flash, external
// - Paged windows rank below flash, above the expanded-mode external default
// - Expanded modes: unclaimed addresses go external
// - Expanded: ports A, B registers external
// - Expanded with E emulation: port E external
// - Peripheral mode: first 16 expansion registers removed
// - Emulation with K emulation: port K external
// - K pin 7: low emulation select on flash in emulation modes
// - K pin 6: low external select in every mode
// - K emulation clear: pins are plain I/O
// - Debug active at once in special single-chip
// - Secure state follows flash bits across resets
`timescale 1ns/100ps
`default_nettype none
`include "map_decoder_defines.vh"
module memory_map_select_decoder
(
    input  wire        clk,
    input  wire        reset,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Mode straps and security
    input  wire        mode_pin_c,
    input  wire        mode_pin_b,
    input  wire        mode_pin_a,
    input  wire        security_bits_set,
    input  wire        debug_serial_activate,
    // Core bus address
    input  wire [15:0] core_address,
    input  wire        core_access,
    input  wire        page_window_hit,
    // One-hot block selects
    output wire        select_debug,
    output wire        select_registers,
    output wire        select_ram,
    output wire        select_eeprom,
    output wire        select_flash,
    output wire        select_external,
    output wire        select_page_window,
    // Port K pins 7 and 6
    input  wire        port_k7_gpio_out,
    input  wire        port_k7_gpio_oe,
    input  wire        port_k6_gpio_out,
    input  wire        port_k6_gpio_oe,
    output wire        port_k7_out,
    output wire        port_k7_oe,
    output wire        port_k6_out,
    output wire        port_k6_oe,
    // Status
    output reg         background_debug_active,
    output wire        secured,
    output wire [2:0]  operating_mode
);
    // Mode codes {c,b,a}
    // Pin c lands in the top bit of the latched code
    localparam [2:0] MODE_SPECIAL_SINGLE = 3'h0;
    localparam [2:0] MODE_EMUL_NARROW    = 3'h1;
    localparam [2:0] MODE_SPECIAL_TEST   = 3'h2;
    localparam [2:0] MODE_EMUL_WIDE      = 3'h3;
    localparam [2:0] MODE_NORMAL_SINGLE  = 3'h4;
    localparam [2:0] MODE_NORMAL_NARROW  = 3'h5;
    localparam [2:0] MODE_PERIPHERAL     = 3'h6;
    localparam [2:0] MODE_NORMAL_WIDE    = 3'h7;

    // Mapping registers and the pending data phase of the register bus
    reg  [7:0]  ram_position;          // RAM base, upper address byte
    reg  [7:0]  register_block_position; // Register base, upper byte
    reg  [7:0]  eeprom_position;       // EEPROM base, upper byte
    reg  [7:0]  misc_system_control;   // ROM enable and emulation bits
    reg         phase_valid;           // Data phase pending
    reg         phase_write;           // Pending access is a write
    reg  [7:0]  phase_addr;            // Pending word address byte
    wire        captured;              // Straps latched
    wire [2:0]  mode;                  // Latched mode

    // Strap and security capture
    mode_latch u_mode_latch
    (
        .clk               (clk),
        .reset             (reset),
        .mode_pin_c        (mode_pin_c),
        .mode_pin_b        (mode_pin_b),
        .mode_pin_a        (mode_pin_a),
        .security_bits_set (security_bits_set),
        .mode              (mode),
        .secured           (secured),
        .captured          (captured)
    );
    // Latched mode goes out for status
    assign operating_mode = mode;

    // Mode classes
    // Expanded modes reach external memory over the expansion bus
    wire expanded  = (mode == MODE_EMUL_NARROW) || (mode == MODE_SPECIAL_TEST) ||
                     (mode == MODE_EMUL_WIDE) || (mode == MODE_NORMAL_NARROW) ||
                     (mode == MODE_NORMAL_WIDE);
    // Emulation modes serve an emulator through the port K selects
    wire emulation = (mode == MODE_EMUL_NARROW) || (mode == MODE_EMUL_WIDE);
    // Peripheral mode gives the bus to a master outside the chip
    wire peripheral = (mode == MODE_PERIPHERAL);
    // Control bits of the misc register
    wire port_e_emulation_enable = misc_system_control[`MISC_PORT_E_EMUL];
    wire port_k_emulation_enable = misc_system_control[`MISC_PORT_K_EMUL];
    wire onchip_rom_enable = misc_system_control[`MISC_ONCHIP_ROM_ENABLE];

    // Region hits from relocatable bases
    // Bases hold the upper address byte; the mask sets the region size
    // Regions may overlap here; the priority chain sorts them out
    wire hit_regs;
    wire hit_ram;
    wire hit_eeprom;
    // Register block, 1K window
    region_match u_match_regs
    (
        .address (core_address),
        .base    ({register_block_position, 8'h00}),
        .mask    (`REG_SPACE_MASK),
        .enable  (1'b1),
        .hit     (hit_regs)
    );
    // RAM, 4K window
    region_match u_match_ram
    (
        .address (core_address),
        .base    ({ram_position, 8'h00}),
        .mask    (`RAM_SPACE_MASK),
        .enable  (1'b1),
        .hit     (hit_ram)
    );
    // EEPROM, 4K window
    region_match u_match_eeprom
    (
        .address (core_address),
        .base    ({eeprom_position, 8'h00}),
        .mask    (`EEPROM_SPACE_MASK),
        .enable  (1'b1),
        .hit     (hit_eeprom)
    );
    // Debug firmware only while debug is active; flash from its fixed base
    wire hit_debug = background_debug_active && (core_address >= `DEBUG_BASE);
    wire hit_flash = onchip_rom_enable && (core_address >= `FLASH_BASE);

    // Register offsets within the register block that leave the chip
    // Offsets only matter where the register block is hit
    wire [9:0] reg_offset = core_address[9:0];
    wire off_ab = expanded && (reg_offset < `PORT_AB_LIMIT);
    wire off_e  = expanded && port_e_emulation_enable &&
                  ((reg_offset == `PORT_E_DATA) || (reg_offset == `PORT_E_DIR));
    wire off_p  = peripheral && (reg_offset < `EXPANSION_LIMIT);
    wire off_k  = emulation && port_k_emulation_enable &&
                  ((reg_offset == `PORT_K_DATA) || (reg_offset == `PORT_K_DIR));
    // Removed registers in peripheral mode fall through to lower blocks
    wire regs_kept = hit_regs && !(off_ab || off_e || off_p || off_k);
    // Moved port registers answer from the external bus instead
    wire regs_moved_out = hit_regs && (off_ab || off_e || off_k);

    // Fixed-priority one-hot select, same cycle as the address
    // The chain order is the priority: the first hit wins, so no two
    // selects can rise together
    // Seven one-hot select bits; none when nothing is hit, external in expanded modes
    reg [6:0] select;
    always @*
    begin
        select = `SEL_NONE;
        if (!core_access)
            select = `SEL_NONE;
        else if (hit_debug)
            select = `SEL_DEBUG;
        else if (regs_kept)
            select = `SEL_REGS;
        else if (regs_moved_out)                             // Ports moved off-chip
            select = `SEL_EXTERNAL;
        else if (hit_ram)
            select = `SEL_RAM;
        else if (hit_eeprom)
            select = `SEL_EEPROM;
        else if (hit_flash)
            select = `SEL_FLASH;
        else if (page_window_hit)                            // Lowest on-chip rank
            select = `SEL_UNMAPPED;
        else if (expanded)
            select = `SEL_EXTERNAL;
        else
            select = `SEL_NONE;
    end
    // Each output is one bit of a one-hot code
    assign select_debug       = select[0];
    assign select_registers   = select[1];
    assign select_ram         = select[2];
    assign select_eeprom      = select[3];
    assign select_flash       = select[4];
    assign select_external    = select[5];
    assign select_page_window = select[6];

    // Chip selects on port K
    // Both are active low; flash and external never coincide
    wire emulation_chip_select = !(emulation && select_flash);
    wire external_chip_select  = !(emulation_chip_select && select_external);
    // Pin ownership follows the emulation bit
    // Pins are outputs while they carry chip selects
    assign port_k7_out = port_k_emulation_enable ? emulation_chip_select : port_k7_gpio_out;
    assign port_k7_oe  = port_k_emulation_enable ? 1'b1 : port_k7_gpio_oe;
    assign port_k6_out = port_k_emulation_enable ? external_chip_select : port_k6_gpio_out;
    assign port_k6_oe  = port_k_emulation_enable ? 1'b1 : port_k6_gpio_oe;

    // Debug activation: at once in special single-chip, else by command
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            background_debug_active <= 1'b0;
        // Held off until the straps are latched
        else if (captured == 1'b0)
            background_debug_active <= 1'b0;
        // Sticky until the next reset
        else if (mode == MODE_SPECIAL_SINGLE || debug_serial_activate)
            background_debug_active <= 1'b1;
    end

    // AHB-Lite slave: zero wait states, always OKAY
    // Registers answer in the data phase that follows
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    // Non-sequential and sequential transfers are taken; idle and busy not
    wire addr_take = hsel && hready && htrans[1];

    // Capture address phase
    // Only the low address byte is decoded; upper bits alias
    // A stall holds the pending phase unchanged
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase_valid <= 1'b0;
            phase_write <= 1'b0;
            phase_addr  <= 8'h00;
        end
        else if (hready)
        begin
            phase_valid <= addr_take;
            phase_write <= hwrite;
            phase_addr  <= haddr[7:0];
        end
    end

    // Register writes in the data phase; reserved slot ignores writes
    // Only the low byte of the write data is kept
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            ram_position            <= `RST_RAM_POSITION;
            register_block_position <= `RST_REG_POSITION;
            eeprom_position         <= `RST_EEPROM_POSITION;
            misc_system_control     <= `RST_MISC_CONTROL;
        end
        // A write lands at the edge that ends its data phase
        else if (phase_valid && phase_write)
        begin
            // Status, reserved and unmapped words take no write
            case (phase_addr)
                `ADDR_RAM_POSITION:    ram_position            <= hwdata[7:0];
                `ADDR_REG_POSITION:    register_block_position <= hwdata[7:0];
                `ADDR_EEPROM_POSITION: eeprom_position         <= hwdata[7:0];
                `ADDR_MISC_CONTROL:    misc_system_control     <= hwdata[7:0];
                default:               ;
            endcase
        end
    end

    // Read data registered at address phase; unmapped reads zero
    // Launched at the address edge so it stands through the data phase
    always @(posedge clk or posedge reset)
    begin
        if (reset)
            hrdata <= 32'h0000_0000;
        // Held between reads
        else if (addr_take && !hwrite)
        begin
            case (haddr[7:0])
                `ADDR_RAM_POSITION:    hrdata <= {24'h000000, ram_position};
                `ADDR_REG_POSITION:    hrdata <= {24'h000000, register_block_position};
                `ADDR_EEPROM_POSITION: hrdata <= {24'h000000, eeprom_position};
                `ADDR_MISC_CONTROL:    hrdata <= {24'h000000, misc_system_control};
                // Debug, security and latched mode
                `ADDR_MODE_STATUS:     hrdata <= {27'h0000000, background_debug_active,
                                                  secured, mode};
                // Select for the core address of this cycle
                `ADDR_SELECT_STATUS:   hrdata <= {25'h0000000, select};
                default:               hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // memory_map_select_decoder
`default_nettype wire

// *** verif/map_decoder_sva.sv ***
// Port assertions for the memory map select decoder
`timescale 1ns/100ps
`default_nettype none
module map_decoder_sva
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        security_bits_set,
    input wire logic        debug_serial_activate,
    input wire logic        core_access,
    input wire logic        select_debug,
    input wire logic        select_registers,
    input wire logic        select_ram,
    input wire logic        select_eeprom,
    input wire logic        select_flash,
    input wire logic        select_external,
    input wire logic        select_page_window,
    input wire logic        port_k7_gpio_oe,
    input wire logic        port_k6_gpio_oe,
    input wire logic        port_k7_out,
    input wire logic        port_k7_oe,
    input wire logic        port_k6_out,
    input wire logic        port_k6_oe,
    input wire logic        background_debug_active,
    input wire logic        secured,
    input wire logic [2:0]  operating_mode
);
    // All block selects side by side
    wire [6:0] sel = {select_page_window, select_external, select_flash, select_eeprom,
                      select_ram, select_registers, select_debug};
    // Emulation modes have strap c low and strap a high
    wire       emul = !operating_mode[2] && operating_mode[0];
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Read address phase aimed at the reserved slot
    sequence rsvd_read;
        hsel && hready && htrans[1] && !hwrite && haddr == 32'h50;
    endsequence
    one_select_a: assert property ($onehot0(sel))
        else $error("more than one block select");
    idle_select_a: assert property (!core_access |-> sel == 7'h00)
        else $error("select without a core access");
    ext_mode_a: assert property (select_external |-> operating_mode != 3'b000
        && operating_mode != 3'b100 && operating_mode != 3'b110)
        else $error("external select outside expanded modes");
    emul_cs_a: assert property (port_k7_oe && !port_k7_gpio_oe
        |-> port_k7_out == !(select_flash && emul))
        else $error("emulation chip select wrong");
    ext_cs_a: assert property (port_k6_oe && !port_k6_gpio_oe
        |-> port_k6_out == !select_external)
        else $error("external chip select wrong");
    debug_start_a: assert property ($rose(background_debug_active) |->
        operating_mode == 3'b000 || $past(debug_serial_activate)
        || $past(debug_serial_activate, 2))
        else $error("debug active without cause");
    rsvd_zero_a: assert property (rsvd_read |=> hrdata == 32'h0)
        else $error("reserved slot read not zero");
    secure_follow_a: assert property (!$past(reset)
        |-> secured == $past(security_bits_set))
        else $error("secured state does not follow flash bits");
endmodule // map_decoder_sva
bind memory_map_select_decoder map_decoder_sva u_sva
(
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .security_bits_set,
    .debug_serial_activate, .core_access, .select_debug, .select_registers, .select_ram,
    .select_eeprom, .select_flash, .select_external, .select_page_window, .port_k7_gpio_oe,
    .port_k6_gpio_oe, .port_k7_out, .port_k7_oe, .port_k6_out, .port_k6_oe,
    .background_debug_active, .secured, .operating_mode
);
`default_nettype wire

// *** verif/core_bus_model.sv ***
// Core bus side model that presents addresses to the decoder
`timescale 1ns/100ps
`default_nettype none
module core_bus_model
(
    input  wire logic        clk,
    input  wire logic [15:0] req_address,
    input  wire logic        req_access,
    input  wire logic        req_page,
    output var  logic [15:0] core_address,
    output var  logic        core_access,
    output var  logic        page_window_hit
);
    // Launch each access just after the edge, as the core does
    always @(posedge clk)
    begin
        core_access     <= req_access;
        page_window_hit <= req_page && req_access;
        // A released bus does not keep its last address
        if (req_access)
            core_address <= req_address;
        else
            core_address <= ~core_address;
    end
endmodule // core_bus_model
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the memory map select decoder
`timescale 1ns/100ps
`default_nettype none
`include "map_decoder_defines.vh"
`define CHK(got, exp) \
    begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
    logic        clk, reset, hsel, hwrite, security_bits_set, debug_serial_activate;
    logic        mode_pin_c, mode_pin_b, mode_pin_a, req_access, req_page;
    logic        port_k7_gpio_out, port_k7_gpio_oe, port_k6_gpio_out, port_k6_gpio_oe;
    logic [31:0] haddr, hwdata, rdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] req_address;
    wire  [31:0] hrdata;
    wire  [15:0] core_address;
    wire  [2:0]  operating_mode;
    wire         hreadyout, core_access, page_window_hit, background_debug_active, secured;
    wire         select_debug, select_registers, select_ram, select_eeprom;
    wire         select_flash, select_external, select_page_window;
    wire         port_k7_out, port_k7_oe, port_k6_out, port_k6_oe, hresp;
    wire  [6:0]  sel = {select_page_window, select_external, select_flash, select_eeprom,
                        select_ram, select_registers, select_debug};
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    core_bus_model bus_model (.clk, .req_address, .req_access, .req_page, .core_address,
                              .core_access, .page_window_hit);
    memory_map_select_decoder dut
    (
        .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .mode_pin_c, .mode_pin_b, .mode_pin_a,
        .security_bits_set, .debug_serial_activate, .core_address, .core_access,
        .page_window_hit, .select_debug, .select_registers, .select_ram, .select_eeprom,
        .select_flash, .select_external, .select_page_window, .port_k7_gpio_out,
        .port_k7_gpio_oe, .port_k6_gpio_out, .port_k6_gpio_oe, .port_k7_out, .port_k7_oe,
        .port_k6_out, .port_k6_oe, .background_debug_active, .secured, .operating_mode
    );
    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Report counts and verdict, then stop
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Reset with the given straps and flash security level
    task automatic do_reset(input logic [2:0] m, input logic s);
        @(posedge clk);
        reset <= 1'b1;
        {mode_pin_c, mode_pin_b, mode_pin_a} <= m;
        security_bits_set <= s;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    // One single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask
    // Read a register and compare the whole word
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        `CHK(rdata, exp)
        `CHK(hresp, 1'b0)
    endtask
    // Present a core address and compare the selects once settled
    task automatic chk_sel(input logic [15:0] a, input logic pw, input logic [6:0] exp);
        @(posedge clk);
        req_address <= a;
        req_page <= pw;
        @(posedge clk);
        @(negedge clk);
        `CHK(sel, exp)
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial
    begin
        reset = 1'b1;
        req_access = 1'b1;
        security_bits_set = 1'b1;
        {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {debug_serial_activate, req_page, mode_pin_c, mode_pin_b, mode_pin_a} = '0;
        {port_k7_gpio_out, port_k7_gpio_oe, port_k6_gpio_out, port_k6_gpio_oe} = '0;
        req_address = 16'h0000;
        // Special single chip: registers and priority
        do_reset(3'b000, 1'b1);
        rd(32'h40, 32'h09);
        rd(32'h44, 32'h00);
        rd(32'h48, 32'h01);
        rd(32'h4C, 32'h0D);
        bus(1'b1, 32'h50, 32'hFF);
        rd(32'h50, 32'h00);
        rd(32'h80, 32'h00);
        bus(1'b1, 32'h40, 32'h39);
        rd(32'h40, 32'h39);
        `CHK(background_debug_active, 1'b1)
        `CHK(secured, 1'b1)
        rd(32'h54, 32'h18);
        chk_sel(16'h0010, 1'b0, `SEL_REGS);
        chk_sel(16'h0500, 1'b0, `SEL_EEPROM);
        chk_sel(16'h3500, 1'b0, `SEL_RAM);
        chk_sel(16'h8000, 1'b1, `SEL_FLASH);
        chk_sel(16'hFF10, 1'b0, `SEL_DEBUG);
        chk_sel(16'h2000, 1'b0, `SEL_NONE);
        chk_sel(16'h2000, 1'b1, `SEL_UNMAPPED);
        @(posedge clk);
        req_access <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK(sel, `SEL_NONE)
        @(posedge clk);
        req_access <= 1'b1;
        $display("test single chip done");
        // Normal expanded narrow: ports leave the map
        do_reset(3'b101, 1'b0);
        `CHK(secured, 1'b0)
        `CHK(operating_mode, 3'b101)
        `CHK(background_debug_active, 1'b0)
        chk_sel(16'h0000, 1'b0, `SEL_EXTERNAL);
        chk_sel(16'h0008, 1'b0, `SEL_EXTERNAL);
        chk_sel(16'h0010, 1'b0, `SEL_REGS);
        chk_sel(16'h2000, 1'b0, `SEL_EXTERNAL);
        `CHK({port_k6_oe, port_k6_out, port_k7_out}, 3'b101)
        bus(1'b1, 32'h4C, 32'h09);
        chk_sel(16'h0008, 1'b0, `SEL_REGS);
        $display("test expanded done");
        // Emulation narrow: chip selects and debug by command
        do_reset(3'b001, 1'b1);
        chk_sel(16'h8000, 1'b0, `SEL_FLASH);
        `CHK({port_k7_oe, port_k7_out, port_k6_out}, 3'b101)
        chk_sel(16'h0032, 1'b0, `SEL_EXTERNAL);
        `CHK({port_k7_out, port_k6_out}, 2'b10)
        `CHK(background_debug_active, 1'b0)
        @(posedge clk);
        debug_serial_activate <= 1'b1;
        @(posedge clk);
        debug_serial_activate <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        `CHK(background_debug_active, 1'b1)
        rd(32'h54, 32'h19);
        bus(1'b1, 32'h4C, 32'h01);
        @(posedge clk);
        port_k7_gpio_out <= 1'b1;
        port_k7_gpio_oe <= 1'b1;
        @(negedge clk);
        `CHK({port_k7_out, port_k7_oe, port_k6_out, port_k6_oe}, 4'b1100)
        $display("test emulation done");
        // Peripheral mode: expansion registers leave the map
        do_reset(3'b110, 1'b0); // No register bus traffic in this mode
        chk_sel(16'h0000, 1'b0, `SEL_RAM);
        chk_sel(16'h000F, 1'b0, `SEL_RAM);
        chk_sel(16'h0010, 1'b0, `SEL_REGS);
        $display("test peripheral done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
